// ---- hdl/axis_pwm_regs.svh ----
// Purpose: constants for the axis pulse width modulator
// Assumes: 250 MHz reference clock
// Notes:   times in their own unit, counts derived
`ifndef AXIS_PWM_REGS_SVH
`define AXIS_PWM_REGS_SVH
`define CLK_FREQ_HZ        250000000
`define TICK_TIME_US       1000
`define TICK_CYCLES        ((`CLK_FREQ_HZ / 1000000) * `TICK_TIME_US)
`define PERIOD_MIN_MS      16'h0001
`define PERIOD_MAX_MS      16'h4E20
`define RATIO_MAX_PCT      16'h0064
`define PCT_SCALE          7'h64
`define AXIS_X_SEL         16'h0000
`define AXIS_Y_SEL         16'h0001
`endif

// ---- hdl/axis_pwm_pkg.sv ----
// Purpose: types for the axis pulse width modulator
// Assumes: none
// Notes:   constants live in axis_pwm_regs.svh
package axis_pwm_pkg;
    typedef enum logic [1:0] {st_idle, st_run, st_hold} pwm_state_t;
endpackage : axis_pwm_pkg

// ---- hdl/ms_tick_gen.sv ----
// Purpose: millisecond enable pulse from the reference clock
// Assumes: ref_clk at 250 MHz
// Notes:   parameter shortens the count for simulation
`timescale 1ns/10ps
`include "axis_pwm_regs.svh"
module ms_tick_gen #(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
    input  wire logic ref_clk,
    input  wire logic rst_b,
    output logic      tick
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } tick_state_t;
    tick_state_t cur_ff;
    tick_state_t nxt_cur;
    always_comb begin
        nxt_cur      = cur_ff;
        nxt_cur.tick = 1'b0;
        if (cur_ff.cnt >= TICK_CYCLES - 1) begin
            nxt_cur.cnt  = 32'h0;
            nxt_cur.tick = 1'b1;
        end else begin
            nxt_cur.cnt = cur_ff.cnt + 32'h1;
        end
    end
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end
    assign tick = cur_ff.tick;
endmodule : ms_tick_gen

// ---- hdl/axis_pulse_width_modulator.sv ----
// Function
// - While requested, the axis pulses at 1..20000 ms, 0..100 percent off.
// - A channel select other than 0 or 1 sets the fault and starts nothing.
// - While modulating, the axis position value does not change.
// - While modulating, running and steady-rate bits of the axis stay at one.
// - While modulating, other motion commands and travel limits are ignored.
// - Halts are ignored while modulating; only dropping the request stops.
// - A period change during modulation does not affect the running output.
// - A busy or faulted axis at request rise does not start modulation.
// Purpose: per-axis pulse width modulated output
// Assumes: request and settings come from logic on ref_clk
// Notes:   off ratio is also latched at start along with the period
`timescale 1ns/10ps
`include "axis_pwm_regs.svh"
module axis_pulse_width_modulator
    import axis_pwm_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        modulation_request_contact,
    input  wire logic [15:0] channel_select,
    input  wire logic [15:0] period_setting,
    input  wire logic [15:0] off_ratio_setting,
    input  wire logic        x_busy,
    input  wire logic        y_busy,
    input  wire logic        x_channel_fault_bit,
    input  wire logic        y_channel_fault_bit,
    input  wire logic        decelerating_halt_cmd,
    input  wire logic        emergency_halt_cmd,
    input  wire logic        motion_cmd,
    input  wire logic        upper_limit,
    input  wire logic        lower_limit,
    input  wire logic [31:0] x_position_in,
    input  wire logic [31:0] y_position_in,
    output logic             pwm_out_x,
    output logic             pwm_out_y,
    output logic             running_bit_x,
    output logic             running_bit_y,
    output logic             steady_rate_bit_x,
    output logic             steady_rate_bit_y,
    output logic             pwm_active,
    output logic             motion_enable,
    output logic             position_hold,
    output logic             instruction_fault_flag
);
    typedef struct packed {
        pwm_state_t  st;
        logic        req_d;
        logic        axis;
        logic [15:0] period;
        logic [15:0] off_ms;
        logic [15:0] ms_cnt;
        logic        out_x;
        logic        out_y;
        logic        fault;
    } pwm_reg_t;

    pwm_reg_t    cur_ff;
    pwm_reg_t    nxt_cur;
    logic        tick;
    logic        req_rise;
    logic        sel_ok;
    logic        ax_sel;
    logic        ax_blocked;
    logic        set_ok;
    logic [31:0] off_prod;
    logic [15:0] period_c;
    logic [15:0] ratio_c;
    logic        phase_on;

    ms_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .tick    (tick)
    );

    assign req_rise = modulation_request_contact & ~cur_ff.req_d;
    assign sel_ok   = (channel_select == `AXIS_X_SEL) ||
                      (channel_select == `AXIS_Y_SEL);
    assign ax_sel   = channel_select[0];
    assign ax_blocked = ax_sel ? (y_busy | y_channel_fault_bit)
                               : (x_busy | x_channel_fault_bit);
    assign set_ok   = (period_setting >= `PERIOD_MIN_MS) &&
                      (period_setting <= `PERIOD_MAX_MS) &&
                      (off_ratio_setting <= `RATIO_MAX_PCT);
    assign period_c = period_setting;
    assign ratio_c  = off_ratio_setting;
    assign off_prod = (32'(period_c) * 32'(ratio_c)) / 32'(`PCT_SCALE);
    assign phase_on = (cur_ff.ms_cnt >= cur_ff.off_ms);

    always_comb begin
        nxt_cur       = cur_ff;
        nxt_cur.req_d = modulation_request_contact;
        unique case (cur_ff.st)
            st_idle: begin
                nxt_cur.out_x = 1'b0;
                nxt_cur.out_y = 1'b0;
                if (req_rise && !sel_ok) begin
                    nxt_cur.fault = 1'b1;
                    nxt_cur.st    = st_hold;
                end else if (req_rise && (ax_blocked || !set_ok)) begin
                    nxt_cur.st = st_hold;
                end else if (req_rise) begin
                    nxt_cur.fault  = 1'b0;
                    nxt_cur.axis   = ax_sel;
                    nxt_cur.period = period_c;
                    nxt_cur.off_ms = off_prod[15:0];
                    nxt_cur.ms_cnt = 16'h0000;
                    nxt_cur.st     = st_run;
                end
            end
            st_run: begin
                if (!modulation_request_contact) begin
                    nxt_cur.st    = st_idle;
                    nxt_cur.out_x = 1'b0;
                    nxt_cur.out_y = 1'b0;
                end else begin
                    if (tick) begin
                        if (cur_ff.ms_cnt >= cur_ff.period - 16'h0001) begin
                            nxt_cur.ms_cnt = 16'h0000;
                        end else begin
                            nxt_cur.ms_cnt = cur_ff.ms_cnt + 16'h0001;
                        end
                    end
                    nxt_cur.out_x = ~cur_ff.axis & phase_on;
                    nxt_cur.out_y = cur_ff.axis & phase_on;
                end
            end
            st_hold: begin
                if (!modulation_request_contact) begin
                    nxt_cur.st = st_idle;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign pwm_active = (cur_ff.st == st_run);
    assign pwm_out_x  = cur_ff.out_x;
    assign pwm_out_y  = cur_ff.out_y;
    assign running_bit_x     = pwm_active & ~cur_ff.axis;
    assign running_bit_y     = pwm_active & cur_ff.axis;
    assign steady_rate_bit_x = pwm_active & ~cur_ff.axis;
    assign steady_rate_bit_y = pwm_active & cur_ff.axis;
    assign motion_enable = ~pwm_active & motion_cmd & ~upper_limit
                           & ~lower_limit & ~decelerating_halt_cmd
                           & ~emergency_halt_cmd;
    assign position_hold = pwm_active;
    assign instruction_fault_flag = cur_ff.fault;

    property p_fault_sel;
        @(posedge ref_clk) disable iff (!rst_b)
        (cur_ff.st == st_idle && req_rise && !sel_ok)
            |=> instruction_fault_flag && !pwm_active;
    endproperty
    a_fault_sel: assert property (p_fault_sel)
        else $error("bad select did not fault");

    property p_status;
        @(posedge ref_clk) disable iff (!rst_b)
        pwm_active |-> (running_bit_x & steady_rate_bit_x) ^
                       (running_bit_y & steady_rate_bit_y);
    endproperty
    a_status: assert property (p_status)
        else $error("status bits wrong while active");

    property p_hold;
        @(posedge ref_clk) disable iff (!rst_b)
        pwm_active |-> position_hold && !motion_enable;
    endproperty
    a_hold: assert property (p_hold)
        else $error("position or motion not frozen");

    property p_halt_ignored;
        @(posedge ref_clk) disable iff (!rst_b)
        (pwm_active && modulation_request_contact &&
         (decelerating_halt_cmd || emergency_halt_cmd)) |=> pwm_active;
    endproperty
    a_halt_ignored: assert property (p_halt_ignored)
        else $error("halt stopped modulation");

    property p_period_frozen;
        @(posedge ref_clk) disable iff (!rst_b)
        (pwm_active && $past(pwm_active)) |-> $stable(cur_ff.period);
    endproperty
    a_period_frozen: assert property (p_period_frozen)
        else $error("period changed during run");

    property p_blocked;
        @(posedge ref_clk) disable iff (!rst_b)
        (cur_ff.st == st_idle && req_rise && ax_blocked) |=> !pwm_active;
    endproperty
    a_blocked: assert property (p_blocked)
        else $error("busy axis started modulation");

    property p_off_phase;
        @(posedge ref_clk) disable iff (!rst_b)
        (pwm_active && modulation_request_contact && !phase_on)
            |=> !pwm_out_x && !pwm_out_y;
    endproperty
    a_off_phase: assert property (p_off_phase)
        else $error("output on during off share");

    property p_stop;
        @(posedge ref_clk) disable iff (!rst_b)
        (pwm_active && !modulation_request_contact)
            |=> !pwm_active ##1 (!pwm_out_x && !pwm_out_y);
    endproperty
    a_stop: assert property (p_stop)
        else $error("output did not stop on request drop");

    c_start_x: cover property (@(posedge ref_clk) disable iff (!rst_b)
        pwm_active && !cur_ff.axis && pwm_out_x);
    c_start_y: cover property (@(posedge ref_clk) disable iff (!rst_b)
        pwm_active && cur_ff.axis && pwm_out_y);
    c_fault: cover property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(instruction_fault_flag));
endmodule : axis_pulse_width_modulator

// ---- verification/tb.sv ----
// Purpose: self-checking bench for axis_pulse_width_modulator
// Assumes: TICK_CYCLES of 4, so one millisecond is four clocks
// Notes:   driver queues expectations, monitor compares them
`timescale 1ns/10ps
module tb;
    logic        ref_clk = 1'b0;
    logic        rst_b   = 1'b0;
    logic        req     = 1'b0;
    logic [15:0] sel     = 16'h0000;
    logic [15:0] per     = 16'h0001;
    logic [15:0] rat     = 16'h0000;
    logic [3:0]  hz      = 4'h0;
    logic [4:0]  cmds    = 5'h00;
    logic [31:0] xpos    = 32'h0;
    logic [31:0] q[$];
    logic [31:0] exp_v;
    logic [31:0] cnt     = 32'h0;
    logic        meas    = 1'b0;
    logic        snap_on = 1'b0;
    logic        kind    = 1'b0;
    int          err_total       = 0;
    int          samples_checked = 0;
    int          seed            = 32'h90a6;
    wire         px, py, rx, ry, sx, sy, act, men, hold, flt;

    axis_pulse_width_modulator #(.TICK_CYCLES(4)) i_dut (
        .ref_clk(ref_clk), .rst_b(rst_b),
        .modulation_request_contact(req), .channel_select(sel),
        .period_setting(per), .off_ratio_setting(rat),
        .x_busy(hz[3]), .y_busy(hz[2]),
        .x_channel_fault_bit(hz[1]), .y_channel_fault_bit(hz[0]),
        .decelerating_halt_cmd(cmds[4]), .emergency_halt_cmd(cmds[3]),
        .motion_cmd(cmds[2]), .upper_limit(cmds[1]),
        .lower_limit(cmds[0]), .x_position_in(xpos),
        .y_position_in(~xpos), .pwm_out_x(px), .pwm_out_y(py),
        .running_bit_x(rx), .running_bit_y(ry),
        .steady_rate_bit_x(sx), .steady_rate_bit_y(sy),
        .pwm_active(act), .motion_enable(men), .position_hold(hold),
        .instruction_fault_flag(flt));

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] e);
        samples_checked++;
        if (got !== e) begin
            err_total++;
            $display("Error at %0t: got %0h expected %0h", $time, got, e);
        end
    endtask : check

    // monitor: counts on-time and compares the oldest note
    always begin
        @(negedge ref_clk);
        #1;
        // selected pin counts one, a pulse on the other pin counts 256
        if (meas)
            cnt = cnt + {31'h0, sel[0] ? py : px}
                      + {23'h0, sel[0] ? px : py, 8'h00};
        else if (!snap_on)
            cnt = 32'h0;
        if (snap_on) begin
            exp_v = q.pop_front();
            check(kind ? cnt : {24'h0, act, rx, ry, sx, sy, hold, men, flt},
                  exp_v);
            // back-to-back measurements must not inherit this count
            cnt = 32'h0;
        end
    end

    task automatic snap(input logic k, input logic [31:0] e);
        q.push_back(e);
        kind = k;
        snap_on = 1'b1;
        @(negedge ref_clk);
        snap_on = 1'b0;
    endtask : snap

    task automatic measure(input logic [31:0] e);
        meas = 1'b1;
        repeat (200) @(negedge ref_clk);
        meas = 1'b0;
        snap(1'b1, e);
    endtask : measure

    task automatic go(input logic [15:0] s, p, r);
        sel = s;
        per = p;
        rat = r;
        xpos = $random(seed);
        req = 1'b1;
        repeat (3) @(negedge ref_clk);
    endtask : go

    task automatic stop();
        req = 1'b0;
        repeat (3) @(negedge ref_clk);
    endtask : stop

    task automatic refuse(input logic [15:0] s, p, r);
        go(s, p, r);
        snap(1'b0, 32'h0);
        stop();
    endtask : refuse

    task automatic run_row(input logic [15:0] s, p, r, input logic [31:0] e);
        cmds = 5'h1F;
        go(s, p, r);
        snap(1'b0, s[0] ? 32'hAC : 32'hD4);
        repeat (37) @(negedge ref_clk);
        measure(e);
        per = 16'h0001 + 16'({$random(seed)} % 20000);
        rat = 16'({$random(seed)} % 101);
        measure(e);
        stop();
        cmds = 5'h04;
        snap(1'b0, 32'h02);
        $display("test run axis %0d period %0d ratio %0d done", s, p, r);
    endtask : run_row

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    initial begin
        #(4 * 25000);
        err_total++;
        results();
    end

    initial begin
        repeat (16) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (2) @(negedge ref_clk);
        snap(1'b0, 32'h0);
        go(16'({$random(seed)}) | 16'h0002, 16'h0005, 16'h0032);
        snap(1'b0, 32'h01);
        stop();
        $display("test bad select done");
        run_row(16'h0000, 16'h0005, 16'h0028, 32'd120);
        run_row(16'h0001, 16'h0005, 16'h0000, 32'd200);
        run_row(16'h0001, 16'h0005, 16'h0064, 32'd0);
        run_row(16'h0000, 16'h0001, 16'h0032, 32'd200);
        run_row(16'h0001, 16'h0002, 16'h0032, 32'd100);
        cmds = 5'h0C;
        snap(1'b0, 32'h00);
        cmds = 5'h00;
        for (int i = 0; i < 4; i++) begin
            hz = 4'h1 << i;
            refuse({15'h0, ~i[0]}, 16'h0005, 16'h0032);
        end
        hz = 4'h0;
        refuse(16'h0000, 16'h0000, 16'h0032);
        refuse(16'h0001, 16'h4E21, 16'h0032);
        refuse(16'h0000, 16'h0005, 16'h0065);
        $display("test refusals done");
        results();
    end
endmodule : tb
